// >>> rtl/uart_sw_flow.sv
// Notes on behaviour
// R1: rx_match_mode picks none, pair one, pair two or both; enable gates all.
// R2: tx_insert_mode picks none, pair one or pair two for insertion; mode both inserts pair one.
// R3: pause match halts transmitter only after current character finishes.
// R4: pause match sets pause_raw_flag; enabled flag drives interrupt output.
// R5: while paused, resume match clears raw flag and lets transmission resume.
// R6: resume_on_any_char: any character resumes; all but pause characters are still stored.
// R7: matched pause/resume characters are not stored, except listed modes.
// R8: line errors do not prevent pause or resume matches.
// R9: occupancy above trigger inserts pause, then sets remote_tx_stopped_flag.
// R10: occupancy below trigger inserts resume and clears stopped flag.
// R11: disabling flow control after pause sent inserts resume, clears flag.
// R12: inserted characters use the normal transmitter framing path.
// R13: software polls stopped flag before reading receive FIFO.
// R14: software never enables hardware and software flow control together.
// R15: resume_match_strategy selects how resume characters are matched.
// R16: mode both needs pause one then pause two back to back.
// R17: pause/resume values sit in writable registers read by both paths.
`timescale 1ns/10ps
`default_nettype none
module uart_sw_flow
    import uart_sfc_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // receiver side
    input wire rx_char_type i_rx,
    input wire logic [LEVEL_W:0] i_rx_fifo_level,
    output logic o_rx_wr,
    output logic [7:0] o_rx_wr_data,
    // transmitter side
    input wire logic i_tx_busy,
    output logic o_tx_halt,
    output logic o_ins_valid,
    output logic [7:0] o_ins_char,
    input wire logic i_ins_done,
    // interrupt
    output logic o_irq
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // which pairs of a mode hold the given character
    function automatic logic [1:0] pair_hit(input logic [1:0] mode,
            input logic [7:0] ch, input logic [7:0] c1,
            input logic [7:0] c2);
        pair_hit = {mode[1] & (ch == c2), mode[0] & (ch == c1)};
    endfunction : pair_hit

    ctrl_type ctrl_ff;
    chars_type chars_ff;
    logic [LEVEL_W-1:0] level_ff;
    logic irq_en_ff;
    logic pause_raw_flag_ff;
    logic remote_tx_stopped_flag_ff;
    logic pause_pend_ff;
    logic prev_p1_ff;
    logic [1:0] pair_ff;
    tx_state_type tx_state_ff;
    logic ins_one_ff;
    logic [31:0] nxt_rdata;
    logic acc;
    logic wr_en;
    logic clr_wr;
    logic flow_on;
    logic paused;
    logic [1:0] pm;
    logic [1:0] rm;
    logic pause_hit;
    logic resume_hit;
    logic spec_hit;
    logic consumed;
    logic above;
    logic below;
    logic ins_on;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    // one wait state: pready rises in the second access cycle
    assign acc = i_psel & i_penable & ~o_pready;
    assign wr_en = acc & i_pwrite;
    assign clr_wr = wr_en & (i_paddr == IRQ_CLR_OFS) & i_pwdata[0];

    always_comb begin
        nxt_rdata = '0;
        case (i_paddr)
            CTRL_OFS: nxt_rdata[CTRL_W-1:0] = ctrl_ff;
            CHARS_OFS: nxt_rdata = chars_ff;
            LEVEL_OFS: nxt_rdata[LEVEL_W-1:0] = level_ff;
            STAT_OFS: nxt_rdata[2:0] = {o_tx_halt,
                remote_tx_stopped_flag_ff, pause_raw_flag_ff};
            IRQ_EN_OFS: nxt_rdata[0] = irq_en_ff;
            default: nxt_rdata = '0;
        endcase
    end

    // bus answer; unmapped addresses return an error, clear reads zero
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end else begin
            o_pready <= acc;
            o_pslverr <= acc & (i_paddr > IRQ_CLR_OFS
                | i_paddr[1:0] != 2'b00);
            o_prdata <= (acc & ~i_pwrite) ? nxt_rdata : '0;
        end
    end

    // writable configuration; values feed comparator and inserter
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_ff <= '0;
            chars_ff <= CHARS_RST;
            level_ff <= LEVEL_RST;
            irq_en_ff <= 1'b0;
        end else if (wr_en) begin
            if (i_paddr == CTRL_OFS)
                ctrl_ff <= i_pwdata[CTRL_W-1:0];
            if (i_paddr == CHARS_OFS)
                chars_ff <= i_pwdata; // R17
            if (i_paddr == LEVEL_OFS)
                level_ff <= i_pwdata[LEVEL_W-1:0];
            if (i_paddr == IRQ_EN_OFS)
                irq_en_ff <= i_pwdata[0];
        end
    end

    // ----------------------------------------------------------------
    // receive matching
    // ----------------------------------------------------------------
    // special character detection turns receive flow control off; insertion stays on
    assign flow_on = ctrl_ff.sw_flow_enable
        & ~ctrl_ff.special_char_detect_en; // R1
    assign paused = pause_pend_ff | o_tx_halt;
    // line error bits are deliberately ignored by the comparators
    assign pm = flow_on ? pair_hit(ctrl_ff.rx_match_mode, i_rx.data,
        chars_ff.pause_char_one, chars_ff.pause_char_two) : 2'b00; // R8
    assign rm = flow_on ? pair_hit(ctrl_ff.rx_match_mode, i_rx.data,
        chars_ff.resume_char_one, chars_ff.resume_char_two) : 2'b00;
    // in mode both the two pause characters must arrive in sequence
    assign pause_hit = i_rx.valid & ~paused
        & ((ctrl_ff.rx_match_mode == MODE_BOTH)
        ? (pm[1] & prev_p1_ff) : (|pm)); // R16
    // strategy 0 wants the pair that paused, 1 any enabled pair
    assign resume_hit = i_rx.valid & paused & flow_on
        & (ctrl_ff.resume_on_any_char // R6
        | (ctrl_ff.resume_match_strategy ? (|rm)
        : (|(rm & pair_ff)))); // R15
    assign spec_hit = i_rx.valid & ctrl_ff.special_char_detect_en
        & (i_rx.data == chars_ff.pause_char_two);
    // resume-any characters and special characters still go to fifo
    assign consumed = ((|pm) | (|rm & ~ctrl_ff.resume_on_any_char))
        & flow_on; // R7

    // tracks last character for the two-character pause sequence
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst)
            prev_p1_ff <= 1'b0;
        else if (i_rx.valid)
            prev_p1_ff <= pm[0]; // R16
    end

    // pause request waits until the character on the wire is done
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pause_pend_ff <= 1'b0;
            o_tx_halt <= 1'b0;
            pair_ff <= 2'b00;
        end else if (resume_hit | ~flow_on) begin
            pause_pend_ff <= 1'b0; // R5
            o_tx_halt <= 1'b0;
        end else if (pause_hit) begin
            pause_pend_ff <= 1'b1;
            pair_ff <= (ctrl_ff.rx_match_mode == MODE_BOTH)
                ? MODE_BOTH : pm;
        end else if (pause_pend_ff & ~i_tx_busy) begin
            pause_pend_ff <= 1'b0;
            o_tx_halt <= 1'b1; // R3
        end
    end

    // raw flag: hardware set wins over a software clear
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst)
            pause_raw_flag_ff <= 1'b0;
        else if (pause_hit | spec_hit)
            pause_raw_flag_ff <= 1'b1; // R4
        else if (resume_hit | clr_wr)
            pause_raw_flag_ff <= 1'b0; // R5
    end

    // interrupt level follows the enabled status one cycle later
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst)
            o_irq <= 1'b0;
        else
            o_irq <= pause_raw_flag_ff & irq_en_ff; // R4
    end

    // forward characters that flow control did not swallow
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rx_wr <= 1'b0;
            o_rx_wr_data <= '0;
        end else begin
            o_rx_wr <= i_rx.valid & ~consumed; // R7
            o_rx_wr_data <= i_rx.data;
        end
    end

    // ----------------------------------------------------------------
    // transmit insertion
    // ----------------------------------------------------------------
    assign ins_on = ctrl_ff.sw_flow_enable
        & (ctrl_ff.tx_insert_mode != MODE_OFF); // R2
    assign above = i_rx_fifo_level > {1'b0, level_ff};
    assign below = i_rx_fifo_level < {1'b0, level_ff};

    // inserted characters enter the normal transmitter, so they get
    // the programmed word length, parity and stop bits
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_state_ff <= TX_IDLE;
            o_ins_valid <= 1'b0;
            o_ins_char <= '0;
            remote_tx_stopped_flag_ff <= 1'b0;
            ins_one_ff <= 1'b0;
        end else begin
            case (tx_state_ff)
                TX_IDLE: begin
                    if (ins_on & above) begin
                        tx_state_ff <= TX_PAUSE; // R9
                        o_ins_valid <= 1'b1; // R12
                        // kept: a disable clears the mode field
                        ins_one_ff <= ctrl_ff.tx_insert_mode[0];
                        o_ins_char <= ctrl_ff.tx_insert_mode[0]
                            ? chars_ff.pause_char_one
                            : chars_ff.pause_char_two;
                    end
                end
                TX_PAUSE: begin
                    if (i_ins_done) begin
                        o_ins_valid <= 1'b0;
                        remote_tx_stopped_flag_ff <= 1'b1; // R9
                        tx_state_ff <= TX_STOPPED;
                    end
                end
                TX_STOPPED: begin
                    if (below | ~ins_on) begin
                        tx_state_ff <= TX_RESUME; // R10 R11
                        o_ins_valid <= 1'b1;
                        o_ins_char <= ins_one_ff
                            ? chars_ff.resume_char_one
                            : chars_ff.resume_char_two;
                    end
                end
                TX_RESUME: begin
                    if (i_ins_done) begin
                        o_ins_valid <= 1'b0;
                        remote_tx_stopped_flag_ff <= 1'b0; // R10 R11
                        tx_state_ff <= TX_IDLE;
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    halt_waits_a: assert property ( // R3
        o_tx_halt & ~$past(o_tx_halt) |-> ~$past(i_tx_busy))
        else $error("halt rose while a character was on the wire");
    raw_set_a: assert property (pause_hit |=> pause_raw_flag_ff) // R4
        else $error("pause match did not set raw flag");
    irq_follow_a: assert property ( // R4
        pause_raw_flag_ff & irq_en_ff |=> o_irq)
        else $error("enabled raw flag gave no interrupt");
    resume_clr_a: assert property ( // R5
        resume_hit & ~pause_hit & ~spec_hit |=> ~pause_raw_flag_ff
        ##0 ~o_tx_halt)
        else $error("resume did not clear flag and halt");
    any_store_a: assert property ( // R6
        resume_hit & ctrl_ff.resume_on_any_char & ~(|pm) |=> o_rx_wr)
        else $error("resume-any character was not stored");
    no_store_a: assert property ( // R7
        i_rx.valid & flow_on & (|pm) |=> ~o_rx_wr)
        else $error("pause character reached the fifo");
    pause_ins_a: assert property ( // R9
        tx_state_ff == TX_IDLE & ins_on & above
        |=> o_ins_valid ##0 ~remote_tx_stopped_flag_ff)
        else $error("pause not inserted above trigger");
    stop_flag_a: assert property ( // R9
        tx_state_ff == TX_PAUSE & i_ins_done
        |=> remote_tx_stopped_flag_ff ##1 remote_tx_stopped_flag_ff)
        else $error("stopped flag not set after pause sent");
    resume_ins_a: assert property ( // R11
        tx_state_ff == TX_STOPPED & ~ins_on
        |=> o_ins_valid ##0 tx_state_ff == TX_RESUME)
        else $error("resume not inserted after disable");
    pair_seq_a: assert property ( // R16
        pause_hit & ctrl_ff.rx_match_mode == MODE_BOTH
        |-> prev_p1_ff & (i_rx.data == chars_ff.pause_char_two))
        else $error("both mode paused without first character");

    pause_seen_c: cover property (pause_hit ##[1:20] o_tx_halt);
    resume_seen_c: cover property (o_tx_halt ##1 resume_hit);
    ins_cycle_c: cover property (
        tx_state_ff == TX_RESUME & i_ins_done);
    spec_seen_c: cover property (spec_hit);
endmodule : uart_sw_flow
`default_nettype wire

// >>> rtl/uart_sfc_pkg.sv
package uart_sfc_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CHARS_OFS = 8'h04;
    localparam logic [7:0] LEVEL_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS = 8'h10;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
    localparam int LEVEL_W = 5;
    localparam logic [31:0] CHARS_RST = 32'h13111311;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h08;
    // ----------------------------------------------------------------
    // match and insertion modes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'b00;
    localparam logic [1:0] MODE_ONE = 2'b01;
    localparam logic [1:0] MODE_TWO = 2'b10;
    localparam logic [1:0] MODE_BOTH = 2'b11;
    // control word, bit 7 downward
    typedef struct packed {
        logic resume_match_strategy;
        logic special_char_detect_en;
        logic resume_on_any_char;
        logic [1:0] tx_insert_mode;
        logic [1:0] rx_match_mode;
        logic sw_flow_enable;
    } ctrl_type;
    localparam int CTRL_W = 8;
    // character registers, bit 31 downward
    typedef struct packed {
        logic [7:0] resume_char_two;
        logic [7:0] pause_char_two;
        logic [7:0] resume_char_one;
        logic [7:0] pause_char_one;
    } chars_type;
    // one received character with its line status
    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } rx_char_type;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PAUSE = 2'b01,
        TX_STOPPED = 2'b10,
        TX_RESUME = 2'b11
    } tx_state_type;
endpackage : uart_sfc_pkg

// >>> bench/uart_far_end_model.sv
`timescale 1ns/10ps
`default_nettype none
module uart_far_end_model #(
    parameter int CHAR_CYC = 12
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // block side
    input wire logic i_tx_halt,
    input wire logic i_ins_valid,
    input wire logic i_data_req,
    output logic o_tx_busy,
    output var logic o_ins_done
);
    logic [7:0] cnt_ff;
    logic from_ins_ff;
    // ------------------------------------------------------------
    // shifter timing
    // ------------------------------------------------------------
    // no insert start in the done cycle, or a held request would go twice
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_ff <= 8'h00;
            from_ins_ff <= 1'b0;
            o_ins_done <= 1'b0;
        end else begin
            o_ins_done <= 1'b0;
            if (cnt_ff != 8'h00) begin
                cnt_ff <= cnt_ff - 8'h01;
                o_ins_done <= from_ins_ff && (cnt_ff == 8'h01);
            end else if (!o_ins_done && i_ins_valid) begin
                cnt_ff <= 8'(CHAR_CYC);
                from_ins_ff <= 1'b1;
            end else if (i_data_req && !i_tx_halt) begin
                cnt_ff <= 8'(CHAR_CYC);
                from_ins_ff <= 1'b0;
            end
        end
    end
    // no hardware handshake exists on this far end
    assign o_tx_busy = (cnt_ff != 8'h00);
endmodule : uart_far_end_model
`default_nettype wire

// >>> bench/uart_software_flow_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module uart_software_flow_control_test
    import uart_sfc_pkg::*;
;
    logic mclk, rst, psel, pen, pwr, pready, pslverr, err;
    logic [7:0] paddr, rx_data, ins_char, wr_last;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] level;
    logic rx_wr, busy, halt, ins_valid, ins_done, data_req, irq;
    rx_char_type rx;
    int fail_count, compares, wr_cnt;

    uart_sw_flow i_uart_sw_flow (
        .i_mclk(mclk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_rx(rx), .i_rx_fifo_level(level), .o_rx_wr(rx_wr),
        .o_rx_wr_data(rx_data), .i_tx_busy(busy), .o_tx_halt(halt),
        .o_ins_valid(ins_valid), .o_ins_char(ins_char),
        .i_ins_done(ins_done), .o_irq(irq));
    uart_far_end_model #(.CHAR_CYC(12)) i_uart_far_end_model (
        .i_mclk(mclk), .i_sys_rst(rst), .i_tx_halt(halt),
        .i_ins_valid(ins_valid), .i_data_req(data_req),
        .o_tx_busy(busy), .o_ins_done(ins_done));
    // ------------------------------------------------------------
    // clock, monitor and helpers
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // mid-cycle sampling keeps clear of the edge race
    always @(negedge mclk) begin
        if (rx_wr === 1'b1) begin
            wr_cnt++;
            wr_last = rx_data;
        end
    end
    task stop_test;
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(negedge mclk);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        @(posedge mclk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rdchk(input string what, input logic [7:0] a,
               input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk
    task send(input logic [7:0] d, input logic e);
        @(posedge mclk);
        rx <= '{1'b1, e, d};
        @(posedge mclk);
        rx <= '0;
        repeat (3) @(negedge mclk);
    endtask : send
    task wait_ins(input logic [7:0] exp);
        int n;
        for (n = 0; n < 40 && ins_valid !== 1'b1; n++) @(negedge mclk);
        chk("insert valid", 32'h1, {31'h0, ins_valid});
        chk("inserted char", {24'h0, exp}, {24'h0, ins_char});
        for (n = 0; n < 40 && ins_valid !== 1'b0; n++) @(negedge mclk);
    endtask : wait_ins
    task poll(input logic [31:0] exp);
        int n;
        for (n = 0; n < 10; n++) begin
            apb(1'b0, STAT_OFS, 32'h0);
            if ((rd & 32'h2) === exp) break;
        end
        chk("stopped flag", exp, rd & 32'h2);
    endtask : poll
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task s_regs;
        rdchk("chars", CHARS_OFS, CHARS_RST);
        rdchk("level", LEVEL_OFS, {27'h0, LEVEL_RST});
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        apb(1'b1, CHARS_OFS, 32'h24232221);
        rdchk("chars", CHARS_OFS, 32'h24232221);
    endtask : s_regs
    task s_rx_one;
        int n0, n;
        n0 = wr_cnt;
        apb(1'b1, IRQ_EN_OFS, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h03);
        @(posedge mclk);
        data_req <= 1'b1;
        @(posedge mclk);
        data_req <= 1'b0;
        send(8'h21, 1'b1);
        chk("halt while busy", 32'h0, {31'h0, halt});
        chk("irq", 32'h1, {31'h0, irq});
        for (n = 0; n < 40 && busy !== 1'b0; n++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        chk("halt", 32'h1, {31'h0, halt});
        rdchk("status", STAT_OFS, 32'h5);
        send(8'h22, 1'b0);
        rdchk("status", STAT_OFS, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        send(8'h41, 1'b0);
        chk("rx writes", n0 + 1, wr_cnt);
        chk("rx data", 32'h41, {24'h0, wr_last});
    endtask : s_rx_one
    task automatic s_rx_modes;
        logic [7:0] ctl [4] = '{8'h04, 8'h01, 8'h03, 8'h05};
        int i, n0;
        // only mode 10 with enable set takes the second pause value
        for (i = 0; i < 4; i++) begin
            apb(1'b1, CTRL_OFS, {24'h0, ctl[i]});
            n0 = wr_cnt;
            send(8'h23, 1'b0);
            chk("rx writes", n0 + ((i == 3) ? 0 : 1), wr_cnt);
            rdchk("status", STAT_OFS, (i == 3) ? 32'h5 : 32'h0);
            send(8'h24, 1'b0);
        end
    endtask : s_rx_modes
    task s_both;
        apb(1'b1, CTRL_OFS, 32'h07);
        @(posedge mclk);
        rx <= '{1'b1, 1'b0, 8'h21};
        @(posedge mclk);
        rx <= '{1'b1, 1'b0, 8'h23};
        @(posedge mclk);
        rx <= '0;
        repeat (3) @(negedge mclk);
        rdchk("status", STAT_OFS, 32'h5);
        send(8'h24, 1'b0);
        rdchk("status", STAT_OFS, 32'h0);
    endtask : s_both
    task s_any;
        int n0;
        apb(1'b1, CTRL_OFS, 32'h23);
        send(8'h21, 1'b0);
        n0 = wr_cnt;
        rdchk("status", STAT_OFS, 32'h5);
        send(8'h55, 1'b0);
        rdchk("status", STAT_OFS, 32'h0);
        chk("rx writes", n0 + 1, wr_cnt);
        chk("rx data", 32'h55, {24'h0, wr_last});
    endtask : s_any
    task s_irq;
        apb(1'b1, IRQ_EN_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h03);
        send(8'h21, 1'b0);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, IRQ_EN_OFS, 32'h1);
        repeat (2) @(negedge mclk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, IRQ_CLR_OFS, 32'h1);
        repeat (2) @(negedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, STAT_OFS, 32'h0);
        chk("raw flag", 32'h0, rd & 32'h1);
        send(8'h22, 1'b0);
        chk("halt", 32'h0, {31'h0, halt});
    endtask : s_irq
    task automatic s_strat;
        int n0;
        // a resume of the other pair only counts under strategy 1
        apb(1'b1, CTRL_OFS, 32'h03);
        send(8'h21, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h05);
        send(8'h24, 1'b0);
        rdchk("status", STAT_OFS, 32'h5);
        apb(1'b1, CTRL_OFS, 32'h85);
        send(8'h24, 1'b0);
        rdchk("status", STAT_OFS, 32'h0);
        // special detection flags the character but keeps it
        apb(1'b1, CTRL_OFS, 32'h41);
        n0 = wr_cnt;
        send(8'h23, 1'b0);
        rdchk("status", STAT_OFS, 32'h1);
        chk("rx writes", n0 + 1, wr_cnt);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, IRQ_CLR_OFS, 32'h1);
    endtask : s_strat
    task automatic s_tx;
        logic [7:0] pch [3] = '{8'h21, 8'h23, 8'h21};
        logic [7:0] rch [3] = '{8'h22, 8'h24, 8'h22};
        int i;
        apb(1'b1, CTRL_OFS, 32'h01);
        @(posedge mclk);
        level <= 6'd9;
        repeat (10) @(negedge mclk);
        chk("insert off", 32'h0, {31'h0, ins_valid});
        // modes one and two pause and resume with their own pair, mode both with pair one
        for (i = 0; i < 3; i++) begin
            @(posedge mclk);
            level <= 6'd0;
            apb(1'b1, CTRL_OFS, 32'(((i + 1) << 3) | 1));
            @(posedge mclk);
            level <= 6'd9;
            wait_ins(pch[i]);
            poll(32'h2);
            @(posedge mclk);
            level <= 6'd7;
            wait_ins(rch[i]);
            poll(32'h0);
        end
        @(posedge mclk);
        level <= 6'd9;
        wait_ins(8'h21);
        poll(32'h2);
        apb(1'b1, CTRL_OFS, 32'h00);
        wait_ins(8'h22);
        poll(32'h0);
    endtask : s_tx
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rx = '0;
        level = 6'h00;
        data_req = 1'b0;
        fail_count = 0;
        compares = 0;
        wr_cnt = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        s_regs();
        s_rx_one();
        s_rx_modes();
        s_both();
        s_any();
        s_irq();
        s_strat();
        s_tx();
        stop_test();
    end
endmodule : uart_software_flow_control_test
`default_nettype wire
